// >>> scu_params.svh
// constants of the serial channel: format codes, oversampling and timing counts
// Function
// - stop centre majority zero sets framing error
// - receive event at bit 8, parity or stop centre
// - transmit event at the start of the stop bit
// - sync transmit event after last active clock edge
// - sync receive event on move into buffer
// - sync mode drives or accepts the shift clock
// - buffer write sends eight bits, then event
// - clock-out mode receives while receive flag clear
// - eight bits in, buffer loaded, receive flag set
// - clock-in mode shifts only while receive flag clear or transmit buffer full
// - format code 01 selects 7-bit mode
// - parity enable and parity sense in 7/8-bit
// - format code 10 selects 8-bit mode
// - format code 11 selects 9-bit, no parity
// - ninth bit from mode, into control register
// - software writes ninth bit before buffer
// - wake-up passes only frames with ninth bit one
// - master addresses slaves with ninth bit one
// - matching slave clears its wake-up enable
// - master sends data with ninth bit zero
// - sixteen ticks per bit, majority of 7,8,9
// - start needs two of three samples zero
// - least significant bit first, event when empty
// - new frame lost when buffer still unread
`ifndef SCU_PARAMS_SVH
`define SCU_PARAMS_SVH
`define SCU_FMT_SYNC 2'h0
`define SCU_FMT_7BIT 2'h1
`define SCU_FMT_8BIT 2'h2
`define SCU_FMT_9BIT 2'h3
`define SCU_OVERSAMPLE 16
`define SCU_PHASE_LAST 4'hF
`define SCU_PHASE_S1 4'h6
`define SCU_PHASE_S2 4'h7
`define SCU_PHASE_CENTRE 4'h8
`define SCU_SYNC_LAST 3'h7
`define SCU_BAUD_DIV 8
`define SCU_FRAME_IDLE 12'hFFF
`endif

// >>> scu_pkg.sv
// types shared by the serial channel and its bench
package scu_pkg;
    typedef logic [1:0] scu_fmt_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP} scu_rx_state_e;
endpackage : scu_pkg

// >>> scu_link_if.sv
// serial link between the channel and its partner
`timescale 1ns/10ps
interface scu_link_if;
    logic devTxd;
    logic hostTxd;
    logic devSclkO;
    logic devSclkOe;
    logic hostSclkO;
    logic hostSclkOe;
    logic sclk;
    // shift clock line idles high when nobody drives it
    assign sclk = devSclkOe ? devSclkO : (hostSclkOe ? hostSclkO : 1'b1);
    modport dev(output devTxd, output devSclkO, output devSclkOe, input hostTxd, input sclk);
    modport host(output hostTxd, output hostSclkO, output hostSclkOe, input devTxd, input sclk);
endinterface : scu_link_if

// >>> scu_device.sv
// serial channel: synchronous shift mode and 7/8/9-bit asynchronous modes
`timescale 1ns/10ps
`include "scu_params.svh"
module scu_device #(
    parameter int BAUD_DIV = `SCU_BAUD_DIV
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // configuration
    input wire scu_pkg::scu_fmt_t frameFormatSelect,
    input wire logic parityEnable,
    input wire logic parityOdd,
    input wire logic wakeupEnable,
    input wire logic clockDirectionSelect,
    input wire logic clockEdgeSelect,
    input wire logic txNinthBit,
    // buffer access
    input wire logic bufWrite,
    input wire logic [7:0] bufWdata,
    input wire logic bufRead,
    input wire logic errClear,
    // status
    output logic [7:0] bufRdata,
    output logic rxNinthBit,
    output logic framingErrorFlag,
    output logic overrunErrorFlag,
    output logic parityErrorFlag,
    output logic rxIrqPending,
    output logic txIrqPending,
    output logic rxDoneIrq,
    output logic txDoneIrq,
    // link
    scu_link_if.dev link
);
    import scu_pkg::*;

    if (BAUD_DIV < 1 || BAUD_DIV > 65535) begin : g_chk
        $error("BAUD_DIV out of range");
    end

    // majority of three samples
    function automatic logic maj3(input logic a, input logic b, input logic c);
        return (a & b) | (a & c) | (b & c);
    endfunction : maj3

    function automatic logic parityOf(input logic [7:0] d, input logic is7, input logic odd);
        logic p;
        p = is7 ? ^d[6:0] : ^d;
        return p ^ odd;
    endfunction : parityOf

    // ------------------------------------------------------------
    // format decode
    // ------------------------------------------------------------
    logic syncMode;
    logic is7;
    logic is9;
    logic hasExtra;
    logic [3:0] lastData;
    logic [3:0] stopIdx;
    assign syncMode = frameFormatSelect == `SCU_FMT_SYNC;
    assign is7 = frameFormatSelect == `SCU_FMT_7BIT;
    assign is9 = frameFormatSelect == `SCU_FMT_9BIT;
    assign hasExtra = is9 | parityEnable;
    assign lastData = is7 ? 4'h6 : 4'h7;
    assign stopIdx = lastData + 4'h2 + {3'h0, hasExtra};

    // ------------------------------------------------------------
    // oversample tick and bit tick
    // ------------------------------------------------------------
    logic [15:0] divCnt_q;
    logic [3:0] txPhase_q;
    logic tick;
    logic bitTick;
    assign tick = divCnt_q == 16'h0;
    assign bitTick = tick && txPhase_q == `SCU_PHASE_LAST;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divCnt_q <= 16'h0;
            txPhase_q <= 4'h0;
        end else begin
            divCnt_q <= tick ? 16'(BAUD_DIV - 1) : divCnt_q - 16'h1;
            if (tick) begin
                txPhase_q <= txPhase_q + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // synchronous shift engine
    // ------------------------------------------------------------
    logic syncActive_q;
    logic sclkOut_q;
    logic sclkPrev_q;
    logic syncRx_q;
    logic [2:0] syncCnt_q;
    logic [7:0] syncSr_q;
    logic txFull_q;
    logic canStart;
    logic extEdge;
    logic intStep;
    logic syncSample;
    logic syncFall;
    logic syncDone;
    logic rxTake;
    assign canStart = txFull_q | ~rxIrqPending;
    assign extEdge = syncMode && clockDirectionSelect &&
        (clockEdgeSelect ? (sclkPrev_q & ~link.sclk) : (~sclkPrev_q & link.sclk));
    assign intStep = syncMode & ~clockDirectionSelect & tick & syncActive_q;
    assign syncSample = (intStep & ~sclkOut_q) | (extEdge & (syncActive_q | canStart));
    assign syncFall = (intStep & sclkOut_q) | (extEdge & (syncActive_q | canStart));
    assign syncDone = syncSample && syncCnt_q == `SCU_SYNC_LAST;
    assign rxTake = syncActive_q ? syncRx_q : ~rxIrqPending;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclkPrev_q <= 1'b1;
        end else begin
            sclkPrev_q <= link.sclk;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncActive_q <= 1'b0;
            sclkOut_q <= 1'b1;
            syncRx_q <= 1'b0;
            syncCnt_q <= 3'h0;
        end else if (!syncMode) begin
            syncActive_q <= 1'b0;
            sclkOut_q <= 1'b1;
            syncCnt_q <= 3'h0;
        end else if (syncSample) begin
            sclkOut_q <= 1'b1;
            syncActive_q <= ~syncDone;
            syncCnt_q <= syncCnt_q + 3'h1;
            if (!syncActive_q) begin
                syncRx_q <= ~rxIrqPending;
            end
        end else if (intStep && sclkOut_q) begin
            sclkOut_q <= 1'b0;
        end else if (!syncActive_q && canStart && !clockDirectionSelect) begin
            syncActive_q <= 1'b1;
            sclkOut_q <= 1'b0;
            syncRx_q <= ~rxIrqPending;
            syncCnt_q <= 3'h0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncSr_q <= 8'h0;
        end else if (syncSample && rxTake) begin
            syncSr_q <= {link.hostTxd, syncSr_q[7:1]};
        end
    end

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    logic [11:0] txSr_q;
    logic [3:0] txIdx_q;
    logic [3:0] txStop_q;
    logic txRun_q;
    logic txAccept;
    logic txEvent;
    logic [11:0] frame;
    assign txAccept = bufWrite & ~txFull_q & ~txRun_q & ~syncActive_q;
    assign txEvent = (bitTick && txRun_q && txIdx_q + 4'h1 == txStop_q)
        || (syncDone && txFull_q);

    always_comb begin
        frame = `SCU_FRAME_IDLE;
        if (syncMode) begin
            frame[7:0] = bufWdata;
        end else begin
            frame[0] = 1'b0;
            // bit 8 is the stop bit in plain 7-bit frames
            frame[8:1] = {bufWdata[7] | is7, bufWdata[6:0]};
            if (is9) begin
                frame[9] = txNinthBit;
            end else if (parityEnable && is7) begin
                frame[8] = parityOf(bufWdata, 1'b1, parityOdd);
            end else if (parityEnable) begin
                frame[9] = parityOf(bufWdata, 1'b0, parityOdd);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txSr_q <= `SCU_FRAME_IDLE;
            txFull_q <= 1'b0;
            txRun_q <= 1'b0;
            txIdx_q <= 4'h0;
            txStop_q <= 4'h0;
        end else if (txAccept) begin
            txSr_q <= frame;
            txFull_q <= 1'b1;
            txStop_q <= stopIdx;
        end else if (syncMode) begin
            txRun_q <= 1'b0;
            if (syncFall && !syncDone) begin
                txSr_q <= {1'b1, txSr_q[11:1]};
            end
            if (syncDone) begin
                txFull_q <= 1'b0;
            end
        end else if (bitTick) begin
            if (txRun_q && txIdx_q == txStop_q) begin
                txRun_q <= 1'b0;
            end else if (txRun_q) begin
                txSr_q <= {1'b1, txSr_q[11:1]};
                txIdx_q <= txIdx_q + 4'h1;
            end else if (txFull_q) begin
                txRun_q <= 1'b1;
                txFull_q <= 1'b0;
                txIdx_q <= 4'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // asynchronous receiver
    // ------------------------------------------------------------
    scu_rx_state_e rxState_q;
    logic [3:0] rxPhase_q;
    logic [3:0] rxCnt_q;
    logic [8:0] rxSr_q;
    logic [1:0] rxSmp_q;
    logic centre;
    logic rxVal;
    logic rxDone;
    logic [8:0] rxWord;
    assign centre = tick && rxState_q != RX_IDLE && rxPhase_q == `SCU_PHASE_CENTRE;
    assign rxVal = maj3(rxSmp_q[0], rxSmp_q[1], link.hostTxd);
    assign rxDone = centre && (rxState_q == RX_EXTRA || (rxState_q == RX_STOP && !hasExtra));

    always_comb begin
        rxWord = rxSr_q;
        if (rxState_q == RX_EXTRA) begin
            rxWord[lastData + 4'h1] = rxVal;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxState_q <= RX_IDLE;
            rxPhase_q <= 4'h0;
            rxCnt_q <= 4'h0;
            rxSr_q <= 9'h0;
            rxSmp_q <= 2'h0;
        end else if (syncMode) begin
            rxState_q <= RX_IDLE;
        end else if (tick) begin
            rxPhase_q <= rxPhase_q + 4'h1;
            if (rxPhase_q == `SCU_PHASE_S1) begin
                rxSmp_q[0] <= link.hostTxd;
            end
            if (rxPhase_q == `SCU_PHASE_S2) begin
                rxSmp_q[1] <= link.hostTxd;
            end
            unique case (rxState_q)
                RX_IDLE: begin
                    rxPhase_q <= 4'h1;
                    if (!link.hostTxd) begin
                        rxState_q <= RX_START;
                        rxSr_q <= 9'h0;
                        rxCnt_q <= 4'h0;
                    end
                end
                RX_START: begin
                    if (centre) begin
                        rxState_q <= rxVal ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (centre) begin
                        rxSr_q[rxCnt_q] <= rxVal;
                        rxCnt_q <= rxCnt_q + 4'h1;
                        if (rxCnt_q == lastData) begin
                            rxState_q <= hasExtra ? RX_EXTRA : RX_STOP;
                        end
                    end
                end
                RX_EXTRA: begin
                    if (centre) begin
                        rxSr_q <= rxWord;
                        rxState_q <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (centre) begin
                        rxState_q <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // receive buffer, flags and events
    // ------------------------------------------------------------
    logic rxLoad;
    logic rxOverrun;
    logic rxParityBad;
    logic rxFrameBad;
    assign rxOverrun = rxDone & rxIrqPending;
    assign rxLoad = (rxDone && !rxIrqPending && !(is9 && wakeupEnable && !rxWord[8]))
        || (syncDone && rxTake);
    assign rxParityBad = rxLoad && !syncMode && parityEnable && !is9 &&
        (is7 ? parityOf(rxWord[7:0], 1'b1, parityOdd) != rxWord[7]
             : parityOf(rxWord[7:0], 1'b0, parityOdd) != rxWord[8]);
    assign rxFrameBad = centre && rxState_q == RX_STOP && !rxVal;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bufRdata <= 8'h0;
            rxNinthBit <= 1'b0;
        end else if (rxLoad) begin
            bufRdata <= syncMode ? {link.hostTxd, syncSr_q[7:1]} : rxWord[7:0];
            rxNinthBit <= rxWord[8];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxIrqPending <= 1'b0;
            rxDoneIrq <= 1'b0;
        end else begin
            // a load in the read cycle keeps the flag set
            rxIrqPending <= rxLoad | (rxIrqPending & ~bufRead);
            rxDoneIrq <= rxLoad;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txIrqPending <= 1'b0;
            txDoneIrq <= 1'b0;
        end else begin
            txIrqPending <= txEvent | (txIrqPending & ~txAccept);
            txDoneIrq <= txEvent;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            framingErrorFlag <= 1'b0;
            overrunErrorFlag <= 1'b0;
            parityErrorFlag <= 1'b0;
        end else begin
            framingErrorFlag <= rxFrameBad | (framingErrorFlag & ~errClear);
            overrunErrorFlag <= rxOverrun | (overrunErrorFlag & ~errClear);
            parityErrorFlag <= rxParityBad | (parityErrorFlag & ~errClear);
        end
    end

    // ------------------------------------------------------------
    // link pins
    // ------------------------------------------------------------
    assign link.devTxd = (syncMode | txRun_q) ? txSr_q[0] : 1'b1;
    assign link.devSclkO = sclkOut_q;
    assign link.devSclkOe = syncMode & ~clockDirectionSelect;
endmodule : scu_device

// >>> scu_host.sv
// partner end: 9-bit addressing master and external shift register
`timescale 1ns/10ps
`include "scu_params.svh"
module scu_host #(
    parameter int BAUD_DIV = `SCU_BAUD_DIV
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // mode
    input wire logic syncMode,
    input wire logic extClockEnable,
    // frame send
    input wire logic sendReq,
    input wire logic [7:0] sendData,
    input wire logic sendIsAddress,
    output logic sendReady,
    // shift register
    input wire logic regLoad,
    input wire logic [7:0] regLoadData,
    output logic [7:0] regData,
    // link
    scu_link_if.host link
);
    if (BAUD_DIV < 1 || BAUD_DIV > 65535) begin : g_chk
        $error("BAUD_DIV out of range");
    end

    logic [15:0] divCnt_q;
    logic [3:0] phase_q;
    logic tick;
    logic bitTick;
    assign tick = divCnt_q == 16'h0;
    assign bitTick = tick && phase_q == `SCU_PHASE_LAST;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divCnt_q <= 16'h0;
            phase_q <= 4'h0;
        end else begin
            divCnt_q <= tick ? 16'(BAUD_DIV - 1) : divCnt_q - 16'h1;
            if (tick) begin
                phase_q <= phase_q + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // frame sender
    // ------------------------------------------------------------
    logic [11:0] txSr_q;
    logic [3:0] txLeft_q;
    assign sendReady = txLeft_q == 4'h0;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txSr_q <= 12'hFFF;
            txLeft_q <= 4'h0;
        end else if (sendReq && sendReady) begin
            // address frames carry ninth bit one, data frames zero
            // leading one: start bit lasts a full bit
            txSr_q <= {1'b1, sendIsAddress, sendData, 1'b0, 1'b1};
            txLeft_q <= 4'hC;
        end else if (bitTick && !sendReady) begin
            txSr_q <= {1'b1, txSr_q[11:1]};
            txLeft_q <= txLeft_q - 4'h1;
        end
    end

    // ------------------------------------------------------------
    // external shift register and optional clock
    // ------------------------------------------------------------
    logic sclkPrev_q;
    logic sclkOut_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclkPrev_q <= 1'b1;
            sclkOut_q <= 1'b1;
        end else begin
            sclkPrev_q <= link.sclk;
            if (!extClockEnable) begin
                sclkOut_q <= 1'b1;
            end else if (tick) begin
                sclkOut_q <= ~sclkOut_q;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regData <= 8'h0;
        end else if (regLoad) begin
            regData <= regLoadData;
        end else if (syncMode && !sclkPrev_q && link.sclk) begin
            regData <= {link.devTxd, regData[7:1]};
        end
    end

    assign link.hostTxd = syncMode ? regData[0] : txSr_q[0];
    assign link.hostSclkO = sclkOut_q;
    assign link.hostSclkOe = extClockEnable;
endmodule : scu_host

// >>> scu_link_properties.sv
// checker for the timing seen on the wires of the serial link
`timescale 1ns/10ps
module scu_link_properties #(
    parameter int BAUD_DIV = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // link wires
    input wire logic devTxd,
    input wire logic hostTxd,
    input wire logic devSclkO,
    input wire logic devSclkOe,
    input wire logic hostSclkO,
    input wire logic hostSclkOe,
    input wire logic sclk
);
    localparam int BITLEN = 16 * BAUD_DIV;
    localparam int PERIOD = 2 * BAUD_DIV;
    localparam int LOWMAX = 2 * BAUD_DIV;
    localparam int IDLE = 4 * BAUD_DIV;
    logic asyncMode;
    logic [15:0] runLen_q;
    logic [15:0] gap_q;
    logic [15:0] hiLen_q;
    logic [3:0] riseCnt_q;
    assign asyncMode = !devSclkOe && !hostSclkOe;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) runLen_q <= 16'hFFFF;
        else if ($changed(devTxd)) runLen_q <= 16'h1;
        else if (runLen_q != 16'hFFFF) runLen_q <= runLen_q + 16'h1;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) gap_q <= 16'hFFFF;
        else if ($rose(sclk)) gap_q <= 16'h1;
        else if (gap_q != 16'hFFFF) gap_q <= gap_q + 16'h1;
    end
    // idle detection splits bursts; a burst cut short shows as a count other than eight
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) hiLen_q <= 16'h0;
        else if (!sclk) hiLen_q <= 16'h0;
        else if (hiLen_q != 16'hFFFF) hiLen_q <= hiLen_q + 16'h1;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) riseCnt_q <= 4'h0;
        else if (hiLen_q == 16'(IDLE)) riseCnt_q <= 4'h0;
        else if (devSclkOe && $rose(sclk)) riseCnt_q <= riseCnt_q + 4'h1;
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    sequence txEdge;
        asyncMode && $changed(devTxd);
    endsequence
    sequence syncFall;
        devSclkOe && $fell(sclk);
    endsequence
    oe_exclusive_a: assert property (!(devSclkOe && hostSclkOe))
        else $error("both ends drive the shift clock");
    tx_bit_len_a: assert property (txEdge |-> runLen_q >= 16'(BITLEN))
        else $error("async transmit bit shorter than sixteen ticks");
    sync_period_a: assert property (devSclkOe && $rose(sclk) |-> gap_q >= 16'(PERIOD))
        else $error("shift clock rises too close together");
    sync_low_a: assert property (syncFall |-> ##[1:LOWMAX] $rose(sclk))
        else $error("shift clock low phase too long");
    sync_burst_a: assert property (devSclkOe && hiLen_q == 16'(IDLE)
        |-> riseCnt_q == 4'h0 || riseCnt_q == 4'h8)
        else $error("shift clock burst is not eight edges");
    tx_idle_reset_a: assert property ($rose(rstn) |-> devTxd)
        else $error("transmit line not idle after reset");
endmodule : scu_link_properties

// >>> testbench.sv
// bench for the serial channel: device and partner joined on one link
`timescale 1ns/10ps
`include "scu_params.svh"
module testbench;
    import scu_pkg::*;
    localparam int BD = 2;
    localparam int BIT = 16 * BD;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    scu_fmt_t fmt = `SCU_FMT_8BIT;
    logic parEn = 1'b0, parOdd = 1'b0, wakeEn = 1'b0, clkDir = 1'b0, clkEdge = 1'b0;
    logic txNinth = 1'b0, bufWr = 1'b0, bufRd = 1'b0, errClr = 1'b0;
    logic hSync = 1'b0, hExt = 1'b0, sendReq = 1'b0, sendAddr = 1'b0, regLoad = 1'b0;
    logic [7:0] wdata = 8'h00, sendData = 8'h00, regLoadData = 8'h00;
    logic [7:0] rdata, regData;
    logic rx9, framing_error_flag, overrun_error_flag, parity_error_flag, rxPend, txPend, rxIrq, txIrq, sendReady;
    int mismatches = 0, samples_checked = 0, nb;
    bit ok;
    logic [9:0] frame, expF;
    scu_fmt_t fmtT[7] = '{`SCU_FMT_8BIT, `SCU_FMT_8BIT, `SCU_FMT_8BIT, `SCU_FMT_7BIT,
        `SCU_FMT_7BIT, `SCU_FMT_7BIT, `SCU_FMT_9BIT};
    logic [7:0] dT[7] = '{8'hB4, 8'h35, 8'h5A, 8'hCB, 8'h4B, 8'h33, 8'h81};
    logic [6:0] peT = 7'b1011011, oddT = 7'b0010010, n9T = 7'b1000000;
    scu_link_if link();
    scu_device #(.BAUD_DIV(BD)) i_scu_device (.clk(clk), .rstn(rstn),
        .frameFormatSelect(fmt), .parityEnable(parEn), .parityOdd(parOdd),
        .wakeupEnable(wakeEn), .clockDirectionSelect(clkDir), .clockEdgeSelect(clkEdge),
        .txNinthBit(txNinth), .bufWrite(bufWr), .bufWdata(wdata), .bufRead(bufRd),
        .errClear(errClr), .bufRdata(rdata), .rxNinthBit(rx9), .framingErrorFlag(framing_error_flag),
        .overrunErrorFlag(overrun_error_flag), .parityErrorFlag(parity_error_flag), .rxIrqPending(rxPend),
        .txIrqPending(txPend), .rxDoneIrq(rxIrq), .txDoneIrq(txIrq), .link(link));
    scu_host #(.BAUD_DIV(BD)) i_scu_host (.clk(clk), .rstn(rstn), .syncMode(hSync),
        .extClockEnable(hExt), .sendReq(sendReq), .sendData(sendData),
        .sendIsAddress(sendAddr), .sendReady(sendReady), .regLoad(regLoad),
        .regLoadData(regLoadData), .regData(regData), .link(link));
    scu_link_properties #(.BAUD_DIV(BD)) i_scu_link_properties (.clk(clk), .rstn(rstn),
        .devTxd(link.devTxd), .hostTxd(link.hostTxd), .devSclkO(link.devSclkO),
        .devSclkOe(link.devSclkOe), .hostSclkO(link.hostSclkO),
        .hostSclkOe(link.hostSclkOe), .sclk(link.sclk));
    initial begin
        forever #5 clk = ~clk;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task print_verdict();
        $display("TB: %0d mismatches in %0d checks", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    task check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // bounded wait; a missed required event ends the run
    task automatic waitHi(ref logic s, input int lim, input bit must, output bit hit);
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(posedge clk);
            hit = (s === 1'b1);
        end
        if (must && !hit) begin
            mismatches++;
            print_verdict();
        end
    endtask : waitHi
    task wr(input logic [7:0] d);
        @(posedge clk);
        bufWr <= 1'b1;
        wdata <= d;
        @(posedge clk);
        bufWr <= 1'b0;
    endtask : wr
    task pulse(input bit clrErr);
        @(posedge clk);
        bufRd <= !clrErr;
        errClr <= clrErr;
        @(posedge clk);
        bufRd <= 1'b0;
        errClr <= 1'b0;
    endtask : pulse
    task send(input logic [7:0] d, input logic a);
        waitHi(sendReady, 40 * BIT, 1'b1, ok);
        sendReq <= 1'b1;
        sendData <= d;
        sendAddr <= a;
        @(posedge clk);
        sendReq <= 1'b0;
    endtask : send
    // samples each bit in its middle, starting from the falling start edge
    task getFrame(input int n, output logic [9:0] v);
        v = '0;
        for (int i = 0; i < 2 * BIT && link.devTxd !== 1'b0; i++) @(posedge clk);
        if (link.devTxd !== 1'b0) begin
            mismatches++;
            print_verdict();
        end
        tick(BIT / 2);
        for (int i = 0; i < n; i++) begin
            tick(BIT);
            v[i] = link.devTxd;
        end
    endtask : getFrame
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        for (int k = 0; k < 7; k++) begin
            @(posedge clk);
            fmt <= fmtT[k];
            parEn <= peT[k];
            parOdd <= oddT[k];
            txNinth <= n9T[k];
            nb = (fmtT[k] == `SCU_FMT_7BIT) ? 7 : 8;
            expF = 10'(dT[k]) & ((10'h1 << nb) - 10'h1);
            if (fmtT[k] == `SCU_FMT_9BIT) begin
                expF[8] = n9T[k];
                nb = 9;
            end else if (peT[k]) begin
                expF[nb] = ^expF ^ oddT[k];
                nb++;
            end
            wr(dT[k]);
            getFrame(nb, frame);
            check(16'(frame), 16'(expF));
            waitHi(txIrq, BIT, 1'b1, ok);
            check(16'({txPend, link.devTxd}), 16'h3);
            tick(BIT);
        end
        @(posedge clk);
        fmt <= `SCU_FMT_9BIT;
        wakeEn <= 1'b1;
        send(8'h3C, 1'b0);
        waitHi(rxIrq, 16 * BIT, 1'b0, ok);
        check(16'({ok, rxPend}), 16'h0);
        send(8'hA7, 1'b1);
        waitHi(rxIrq, 16 * BIT, 1'b1, ok);
        check(16'(link.hostTxd), 16'h1);
        tick(1);
        check(16'({rx9, rdata}), 16'h1A7);
        @(posedge clk);
        wakeEn <= 1'b0;
        send(8'h12, 1'b0);
        waitHi(overrun_error_flag, 16 * BIT, 1'b1, ok);
        check(16'({rxPend, rx9, rdata}), 16'h3A7);
        pulse(1'b1);
        pulse(1'b0);
        tick(1);
        check(16'({overrun_error_flag, rxPend}), 16'h0);
        send(8'h55, 1'b0);
        waitHi(rxIrq, 16 * BIT, 1'b1, ok);
        check(16'(link.hostTxd), 16'h0);
        tick(BIT);
        check(16'({framing_error_flag, parity_error_flag, rx9, rdata}), 16'h055);
        pulse(1'b0);
        @(posedge clk);
        hSync <= 1'b1;
        regLoad <= 1'b1;
        regLoadData <= 8'hA5;
        @(posedge clk);
        regLoad <= 1'b0;
        fmt <= `SCU_FMT_SYNC;
        waitHi(rxIrq, 40 * BD, 1'b1, ok);
        tick(1);
        check(16'({rxPend, rdata}), 16'h1A5);
        tick(20);
        wr(8'h3C);
        waitHi(txIrq, 40 * BD, 1'b1, ok);
        tick(1);
        check(16'({txPend, regData}), 16'h13C);
        tick(20);
        // external clock, each active edge choice
        for (int e = 0; e < 2; e++) begin
            @(posedge clk);
            clkDir <= 1'b1;
            hExt <= 1'b1;
            clkEdge <= e[0];
            pulse(1'b0);
            waitHi(rxIrq, 80 * BD, 1'b1, ok);
            check(16'(ok), 16'h1);
            waitHi(rxIrq, 40 * BD, 1'b0, ok);
            check(16'(ok), 16'h0);
            wr(8'hC3);
            waitHi(txIrq, 80 * BD, 1'b1, ok);
            check(16'(txPend), 16'h1);
        end
        print_verdict();
    end
endmodule : testbench
